// >>> rtl/motor_loop_speed_profile_regs.sv
// apb register bank for closed-loop tuning and speed-profile settings
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "motor_loop_defines.svh"

module motor_loop_speed_profile_regs (
   // clock, reset, enable
   input  wire logic                           i_ref_clk,
   input  wire logic                           i_srst,
   input  wire logic                           i_clk_en,
   // apb slave
   input  wire logic                           i_psel,
   input  wire logic                           i_penable,
   input  wire logic                           i_pwrite,
   input  wire logic [`ADDR_W-1:0]             i_paddr,
   input  wire logic [31:0]                    i_pwdata,
   output logic      [31:0]                    o_prdata,
   output logic                                o_pready,
   output logic                                o_pslverr,
   // decoded settings
   output motor_loop_pkg::loop_cfg_t           o_loop_cfg,
   output motor_loop_pkg::profile_cfg_t        o_profile_cfg
);

   //----------------------------------------------------------------
   // address decode
   //----------------------------------------------------------------
   localparam logic [7:0] WORD_IDX [`NUM_WORDS] = '{
      `IDX_CLOSED_LOOP_THREE, `IDX_CLOSED_LOOP_FOUR, `IDX_PROFILE_ONE,
      `IDX_PROFILE_TWO, `IDX_PROFILE_THREE, `IDX_PROFILE_FOUR, `IDX_PROFILE_FIVE
   };
   localparam logic [31:0] WORD_MASK [`NUM_WORDS] = '{
      `MASK_FULL, `MASK_FULL, `MASK_FULL, `MASK_FULL, `MASK_FULL, `MASK_FULL,
      `MASK_PROFILE_FIVE
   };

   logic [31:0]            word       [`NUM_WORDS];
   logic [`NUM_WORDS-1:0]  hit;
   logic [31:0]            status_word;
   logic [31:0]            next_prdata;
   logic                   status_hit;
   logic                   mapped;
   logic                   setup_phase;
   logic                   write_take;
   logic                   aligned;

   // a transfer stalls while the block is frozen
   assign o_pready    = i_clk_en;
   assign setup_phase = i_psel & ~i_penable;
   assign write_take  = i_psel & i_penable & i_pwrite & i_clk_en;
   assign aligned     = (i_paddr[1:0] == 2'b00);
   assign status_hit  = aligned & (i_paddr[`ADDR_W-1:2] == {2'b00, `IDX_STATUS});
   assign mapped      = (|hit) | status_hit;

   //----------------------------------------------------------------
   // storage, one flop word per writable register
   //----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_WORDS; gi++) begin : g_word
         assign hit[gi] = aligned & (i_paddr[`ADDR_W-1:2] == {2'b00, WORD_IDX[gi]});
         always_ff @(posedge i_ref_clk) begin
            if (i_srst) begin
               word[gi] <= `WORD_RESET;
            end else if (write_take && hit[gi]) begin
               word[gi] <= i_pwdata & WORD_MASK[gi];
            end
         end
      end
   endgenerate

   //----------------------------------------------------------------
   // read path, data captured in the setup cycle
   //----------------------------------------------------------------
   always_comb begin
      next_prdata = 32'h00000000;
      for (int k = 0; k < `NUM_WORDS; k++) begin
         if (hit[k]) begin
            next_prdata = word[k];
         end
      end
      if (status_hit) begin
         next_prdata = status_word;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_prdata  <= 32'h00000000;
         o_pslverr <= 1'b0;
      end else if (i_clk_en && setup_phase) begin
         o_prdata  <= i_pwrite ? 32'h00000000 : next_prdata;
         o_pslverr <= ~mapped | (i_pwrite & status_hit);
      end
   end

   //----------------------------------------------------------------
   // closed-loop fields
   //----------------------------------------------------------------
   // back-emf code
   assign o_loop_cfg.back_emf_constant = word[0][`BEMF_MSB:`BEMF_LSB];
   assign o_loop_cfg.current_prop_gain = word[0][`CKP_MSB:`CKP_LSB];
   assign o_loop_cfg.current_integ_gain = word[0][`CKI_MSB:`CKI_LSB];
   assign o_loop_cfg.current_gain_auto =
      (word[0][`CKP_MSB:`CKP_LSB] == 10'h000) & (word[0][`CKI_MSB:`CKI_LSB] == 10'h000);
   assign o_loop_cfg.velocity_prop_gain =
      {word[0][`VKP_HI_MSB:`VKP_HI_LSB], word[1][`VKP_LO_MSB:`VKP_LO_LSB]};
   assign o_loop_cfg.velocity_integ_gain = word[1][`VKI_MSB:`VKI_LSB];
   assign o_loop_cfg.max_speed_code = word[1][`MAXSPD_MSB:`MAXSPD_LSB];

   //----------------------------------------------------------------
   // speed-profile fields
   //----------------------------------------------------------------
   logic speed_ref_mode;

   assign o_profile_cfg.profile_type_select =
      motor_loop_pkg::profile_type_t'(word[2][`PTYPE_MSB:`PTYPE_LSB]);
   assign speed_ref_mode =
      (o_profile_cfg.profile_type_select == motor_loop_pkg::PROFILE_SPEED_REF);

   assign o_profile_cfg.turn_on_duty_first  = word[2][`ON1_MSB:`ON1_LSB];
   assign o_profile_cfg.turn_off_duty_first = word[2][`OFF1_MSB:`OFF1_LSB];
   assign o_profile_cfg.clamp_duty_first    = word[2][`CLAMP1_MSB:`CLAMP1_LSB];

   assign o_profile_cfg.duty_a =
      {word[2][`DA_HI_MSB:`DA_HI_LSB], word[3][`DA_LO_MSB:`DA_LO_LSB]};
   assign o_profile_cfg.duty_b = word[3][`DB_MSB:`DB_LSB];
   assign o_profile_cfg.duty_c = word[3][`DC_MSB:`DC_LSB];
   assign o_profile_cfg.duty_d = word[3][`DD_MSB:`DD_LSB];
   assign o_profile_cfg.duty_e =
      {word[3][`DE_HI_MSB:`DE_HI_LSB], word[4][`DE_LO_MSB:`DE_LO_LSB]};

   assign o_profile_cfg.turn_on_duty_second  = word[4][`ON2_MSB:`ON2_LSB];
   assign o_profile_cfg.turn_off_duty_second = word[4][`OFF2_MSB:`OFF2_LSB];
   assign o_profile_cfg.clamp_duty_second    = word[4][`CLAMP2_MSB:`CLAMP2_LSB];

   assign o_profile_cfg.duty_hysteresis = speed_ref_mode ?
      motor_loop_pkg::duty_hysteresis_t'(word[4][`HYST_MSB:`HYST_LSB]) :
      motor_loop_pkg::HYST_NONE;

   assign o_profile_cfg.turn_off_rate_first = word[5][`SOFF1_MSB:`SOFF1_LSB];
   assign o_profile_cfg.clamp_rate_first    = word[5][`SCLAMP1_MSB:`SCLAMP1_LSB];
   assign o_profile_cfg.speed_a = word[5][`SA_MSB:`SA_LSB];
   assign o_profile_cfg.speed_b =
      {word[5][`SB_HI_MSB:`SB_HI_LSB], word[6][`SB_LO_BIT]};

   //----------------------------------------------------------------
   // status word
   //----------------------------------------------------------------
   // bit 0 auto current gains, bits 2-1 profile type, bits 4-3 applied hysteresis
   assign status_word = {27'h0000000, o_profile_cfg.duty_hysteresis,
                         o_profile_cfg.profile_type_select, o_loop_cfg.current_gain_auto};

endmodule : motor_loop_speed_profile_regs

// >>> rtl/motor_loop_defines.svh
// register offsets, field positions and reset values of the loop and profile bank
`ifndef MOTOR_LOOP_DEFINES_SVH
`define MOTOR_LOOP_DEFINES_SVH

// register indices as printed; byte address is four times the index
`define IDX_CLOSED_LOOP_THREE   8'h8c
`define IDX_CLOSED_LOOP_FOUR    8'h8e
`define IDX_PROFILE_ONE         8'h94
`define IDX_PROFILE_TWO         8'h96
`define IDX_PROFILE_THREE       8'h98
`define IDX_PROFILE_FOUR        8'h9a
`define IDX_PROFILE_FIVE        8'h9c
`define IDX_STATUS              8'ha0

// bus geometry
`define ADDR_W                  12
`define NUM_WORDS               7
`define WORD_RESET              32'h00000000

// storable bits per word; the fifth profile word keeps only bits 31-30 here
`define MASK_FULL               32'hffffffff
`define MASK_PROFILE_FIVE       32'hc0000000

// closed-loop word three
`define BEMF_MSB                30
`define BEMF_LSB                23
`define CKP_MSB                 22
`define CKP_LSB                 13
`define CKI_MSB                 12
`define CKI_LSB                 3
`define VKP_HI_MSB              2
`define VKP_HI_LSB              0

// closed-loop word four
`define VKP_LO_MSB              30
`define VKP_LO_LSB              24
`define VKI_MSB                 23
`define VKI_LSB                 14
`define MAXSPD_MSB              13
`define MAXSPD_LSB              0

// profile word one
`define PTYPE_MSB               30
`define PTYPE_LSB               29
`define ON1_MSB                 28
`define ON1_LSB                 21
`define OFF1_MSB                20
`define OFF1_LSB                13
`define CLAMP1_MSB              12
`define CLAMP1_LSB              5
`define DA_HI_MSB               4
`define DA_HI_LSB               0

// profile word two
`define DA_LO_MSB               30
`define DA_LO_LSB               28
`define DB_MSB                  27
`define DB_LSB                  20
`define DC_MSB                  19
`define DC_LSB                  12
`define DD_MSB                  11
`define DD_LSB                  4
`define DE_HI_MSB               3
`define DE_HI_LSB               0

// profile word three
`define DE_LO_MSB               30
`define DE_LO_LSB               27
`define ON2_MSB                 26
`define ON2_LSB                 19
`define OFF2_MSB                18
`define OFF2_LSB                11
`define CLAMP2_MSB              10
`define CLAMP2_LSB              3
`define HYST_MSB                2
`define HYST_LSB                1

// profile word four and five
`define SOFF1_MSB               30
`define SOFF1_LSB               23
`define SCLAMP1_MSB             22
`define SCLAMP1_LSB             15
`define SA_MSB                  14
`define SA_LSB                  7
`define SB_HI_MSB               6
`define SB_HI_LSB               0
`define SB_LO_BIT               30

`endif

// >>> rtl/motor_loop_pkg.sv
// types shared by the loop and profile register bank
package motor_loop_pkg;

   typedef enum logic [1:0] {
      PROFILE_SPEED_REF,
      PROFILE_LINEAR,
      PROFILE_STAIRCASE,
      PROFILE_FWD_REV
   } profile_type_t;

   typedef enum logic [1:0] {
      HYST_NONE,
      HYST_HALF_PCT,
      HYST_ONE_PCT,
      HYST_TWO_PCT
   } duty_hysteresis_t;

   typedef struct packed {
      logic [7:0]  back_emf_constant;
      logic [9:0]  current_prop_gain;
      logic [9:0]  current_integ_gain;
      logic        current_gain_auto;
      logic [9:0]  velocity_prop_gain;
      logic [9:0]  velocity_integ_gain;
      logic [13:0] max_speed_code;
   } loop_cfg_t;

   typedef struct packed {
      profile_type_t profile_type_select;
      logic [7:0]    turn_on_duty_first;
      logic [7:0]    turn_off_duty_first;
      logic [7:0]    clamp_duty_first;
      logic [7:0]    duty_a;
      logic [7:0]    duty_b;
      logic [7:0]    duty_c;
      logic [7:0]    duty_d;
      logic [7:0]    duty_e;
      logic [7:0]    turn_on_duty_second;
      logic [7:0]    turn_off_duty_second;
      logic [7:0]    clamp_duty_second;
      duty_hysteresis_t    duty_hysteresis;
      logic [7:0]    turn_off_rate_first;
      logic [7:0]    clamp_rate_first;
      logic [7:0]    speed_a;
      logic [7:0]    speed_b;
   } profile_cfg_t;

endpackage : motor_loop_pkg

// >>> verification/motor_loop_speed_profile_regs_props.sv
// concurrent checks on the ports of the loop and profile register bank
`timescale 1ns/1ps
`include "motor_loop_defines.svh"
module motor_loop_speed_profile_regs_props (
   // clock, reset, enable
   input wire logic                         i_ref_clk,
   input wire logic                         i_srst,
   input wire logic                         i_clk_en,
   // apb slave
   input wire logic                         i_psel,
   input wire logic                         i_penable,
   input wire logic                         i_pwrite,
   input wire logic [`ADDR_W-1:0]           i_paddr,
   input wire logic [31:0]                  i_pwdata,
   input wire logic [31:0]                  o_prdata,
   input wire logic                         o_pready,
   input wire logic                         o_pslverr,
   // decoded settings
   input wire motor_loop_pkg::loop_cfg_t    o_loop_cfg,
   input wire motor_loop_pkg::profile_cfg_t o_profile_cfg
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   wire logic wr = i_psel & i_penable & i_pwrite & i_clk_en;
   property p_ready; o_pready == i_clk_en; endproperty
   property p_bemf; wr && i_paddr == 12'h230
      |=> o_loop_cfg.back_emf_constant == $past(i_pwdata[30:23]); endproperty
   property p_ckp; wr && i_paddr == 12'h230
      |=> o_loop_cfg.current_prop_gain == $past(i_pwdata[22:13]); endproperty
   property p_cki; wr && i_paddr == 12'h230
      |=> o_loop_cfg.current_integ_gain == $past(i_pwdata[12:3]); endproperty
   property p_auto; o_loop_cfg.current_gain_auto == (o_loop_cfg.current_prop_gain == 10'h000
      && o_loop_cfg.current_integ_gain == 10'h000); endproperty
   property p_vkp; wr && i_paddr == 12'h238
      |=> o_loop_cfg.velocity_prop_gain[6:0] == $past(i_pwdata[30:24]); endproperty
   property p_vki; wr && i_paddr == 12'h238
      |=> o_loop_cfg.velocity_integ_gain == $past(i_pwdata[23:14]); endproperty
   property p_misalign; i_psel && !i_penable && i_clk_en && i_paddr[1:0] != 2'b00
      |=> o_pslverr; endproperty
   property p_max; wr && i_paddr == 12'h238
      |=> o_loop_cfg.max_speed_code == $past(i_pwdata[13:0]); endproperty
   property p_ptype; wr && i_paddr == 12'h250
      |=> o_profile_cfg.profile_type_select == $past(i_pwdata[30:29]); endproperty
   property p_hyst; o_profile_cfg.profile_type_select != motor_loop_pkg::PROFILE_SPEED_REF
      |-> o_profile_cfg.duty_hysteresis == motor_loop_pkg::HYST_NONE; endproperty
   property p_spdb; wr && i_paddr == 12'h270
      |=> o_profile_cfg.speed_b[0] == $past(i_pwdata[30]); endproperty
   a_ready: assert property (p_ready) else $error("pready differs from enable");
   a_bemf: assert property (p_bemf) else $error("back emf field wrong");
   a_ckp: assert property (p_ckp) else $error("current prop gain wrong");
   a_cki: assert property (p_cki) else $error("current integ gain wrong");
   a_auto: assert property (p_auto) else $error("auto gain flag wrong");
   a_vkp: assert property (p_vkp) else $error("velocity prop gain wrong");
   a_vki: assert property (p_vki) else $error("velocity integ gain wrong");
   a_misalign: assert property (p_misalign) else $error("misaligned access not refused");
   a_max: assert property (p_max) else $error("max speed wrong");
   a_ptype: assert property (p_ptype) else $error("profile type wrong");
   a_hyst: assert property (p_hyst) else $error("hysteresis applied wrongly");
   a_spdb: assert property (p_spdb) else $error("speed b low bit wrong");
   c_stall: cover property (i_psel && i_penable && !o_pready);
   c_auto: cover property (o_loop_cfg.current_gain_auto);
   c_err: cover property (i_psel && i_penable && o_pready && o_pslverr);
endmodule : motor_loop_speed_profile_regs_props

// >>> verification/test_motor_loop_speed_profile_regs.sv
// self-checking bench for the loop and profile register bank
`timescale 1ns/1ps
`include "motor_loop_defines.svh"
module test_motor_loop_speed_profile_regs;
   logic                         i_ref_clk = 1'b0;
   logic                         i_srst    = 1'b1;
   logic                         i_clk_en  = 1'b1;
   logic                         i_psel    = 1'b0;
   logic                         i_penable = 1'b0;
   logic                         i_pwrite  = 1'b0;
   logic [`ADDR_W-1:0]           i_paddr   = 12'h000;
   logic [31:0]                  i_pwdata  = 32'h00000000;
   logic [31:0]                  o_prdata;
   logic                         o_pready;
   logic                         o_pslverr;
   logic [31:0]                  rd;
   logic                         er;
   motor_loop_pkg::loop_cfg_t    lc;
   motor_loop_pkg::profile_cfg_t pc;
   int                           bad_count   = 0;
   int                           check_count = 0;
   logic [11:0] adr [7] = '{12'h230, 12'h238, 12'h250, 12'h258, 12'h260, 12'h268, 12'h270};
   logic [31:0] val [7] = '{32'hcafe1235, 32'h5a3c96e1, 32'hb3d57a2c, 32'h6e91c4b7,
                            32'h9d2b58e6, 32'h47a5f31d, 32'hffffffff};
   motor_loop_speed_profile_regs i_dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
      .i_clk_en(i_clk_en), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
      .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .o_loop_cfg(lc), .o_profile_cfg(pc));
   initial forever #20 i_ref_clk = ~i_ref_clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 50);
      if (n >= 50) bad_count++;
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : xfer
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results
   initial begin
      repeat (5000) @(posedge i_ref_clk);
      bad_count++;
      results();
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      for (int k = 0; k < 7; k++) begin
         xfer(1'b0, adr[k], 32'h00000000);
         check(rd, 32'h00000000);
      end
      for (int k = 0; k < 7; k++) begin
         xfer(1'b1, adr[k], val[k]);
         check(32'(er), 32'h00000000);
         xfer(1'b0, adr[k], 32'h00000000);
         check(rd, (k == 6) ? 32'hc0000000 : val[k]);
      end
      check(32'(lc.back_emf_constant), 32'(val[0][30:23]));
      check(32'(lc.current_prop_gain), 32'(val[0][22:13]));
      check(32'(lc.current_integ_gain), 32'(val[0][12:3]));
      check(32'(lc.velocity_prop_gain), 32'({val[0][2:0], val[1][30:24]}));
      check(32'(lc.velocity_integ_gain), 32'(val[1][23:14]));
      check(32'(lc.max_speed_code), 32'(val[1][13:0]));
      check({8'h00, pc.turn_on_duty_first, pc.turn_off_duty_first, pc.clamp_duty_first},
            {8'h00, val[2][28:5]});
      check(32'(pc.duty_a), 32'({val[2][4:0], val[3][30:28]}));
      check({8'h00, pc.duty_b, pc.duty_c, pc.duty_d}, {8'h00, val[3][27:4]});
      check(32'(pc.duty_e), 32'({val[3][3:0], val[4][30:27]}));
      check({8'h00, pc.turn_on_duty_second, pc.turn_off_duty_second, pc.clamp_duty_second},
            {8'h00, val[4][26:3]});
      check({8'h00, pc.turn_off_rate_first, pc.clamp_rate_first, pc.speed_a},
            {8'h00, val[5][30:7]});
      check(32'(pc.speed_b), 32'({val[5][6:0], val[6][30]}));
      xfer(1'b1, 12'h230, 32'h7f800007);
      xfer(1'b0, 12'h280, 32'h00000000);
      check(32'(lc.current_gain_auto), 32'h00000001);
      check(32'(rd[0]), 32'h00000001);
      xfer(1'b1, 12'h230, 32'h00002000);
      xfer(1'b0, 12'h280, 32'h00000000);
      check(32'(lc.current_gain_auto), 32'h00000000);
      for (int t = 0; t < 4; t++) begin
         for (int h = 0; h < 4; h++) begin
            xfer(1'b1, 12'h250, {1'b0, 2'(t), 29'h00000000});
            xfer(1'b1, 12'h260, {29'h00000000, 2'(h), 1'b0});
            xfer(1'b0, 12'h280, 32'h00000000);
            check(32'(pc.profile_type_select), 32'(t));
            check(rd, {27'h0, (t == 0) ? 2'(h) : 2'b00, 2'(t), 1'b0});
         end
      end
      xfer(1'b1, 12'h280, 32'hffffffff);
      check(32'(er), 32'h00000001);
      xfer(1'b0, 12'h234, 32'h00000000);
      check({rd[31:1], er}, 32'h00000001);
      // misaligned write is refused and leaves loop word four alone
      xfer(1'b1, 12'h23a, 32'h00000000);
      check(32'(er), 32'h00000001);
      xfer(1'b0, 12'h238, 32'h00000000);
      check(rd, val[1]);
      xfer(1'b0, 12'h232, 32'h00000000);
      check({rd[31:1], er}, 32'h00000001);
      fork
         xfer(1'b1, 12'h238, 32'h12345678);
         begin
            repeat (2) @(posedge i_ref_clk);
            i_clk_en <= 1'b0;
            repeat (3) @(posedge i_ref_clk);
            i_clk_en <= 1'b1;
         end
      join
      xfer(1'b0, 12'h238, 32'h00000000);
      check(rd, 32'h12345678);
      check(32'(lc.max_speed_code), 32'h00001678);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      xfer(1'b0, 12'h238, 32'h00000000);
      check(rd, 32'h00000000);
      results();
   end
endmodule : test_motor_loop_speed_profile_regs
bind motor_loop_speed_profile_regs motor_loop_speed_profile_regs_props i_props (
   .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_clk_en(i_clk_en), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_loop_cfg(o_loop_cfg), .o_profile_cfg(o_profile_cfg));
